// File: verilog/serial_flash_loader_link.sv
// Port selection, async baud detection and framing for the serial loader.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_loader_link
	import loader_link_pkg::*;
(
	// Clock and reset (crystal clock, no PLL).
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Asynchronous port pins.
	input wire logic async_rx_i,
	output logic async_tx_o,
	// Synchronous port pins.
	input wire logic sclk_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic miso_oe_n_o,
	// Received payload bytes (zeros dropped).
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	// Outgoing byte request from the packet engine.
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	// Packet verdict: pulse to send acknowledge or negative acknowledge.
	input wire logic verdict_valid_i,
	input wire logic verdict_good_i,
	// Status.
	output logic baud_locked_o,
	output logic [1:0] port_o,
	output logic [DIV_W-1:0] divisor_o
);

	// ==========================================================================
	// Pin input filtering: three flops, change taken when stages two and three agree.
	logic [2:0] rx_sh_reg, sck_sh_reg, sel_sh_reg, mosi_sh_reg;
	logic rx_f_reg, sck_f_reg, sel_f_reg, mosi_f_reg;

	// Shift each pin through three flops; stages two and three feed the agreement filter.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_sh_reg <= 3'h7;
			sck_sh_reg <= 3'h7;
			sel_sh_reg <= 3'h7;
			mosi_sh_reg <= 3'h0;
			rx_f_reg <= 1'b1;
			sck_f_reg <= 1'b1;
			sel_f_reg <= 1'b1;
			mosi_f_reg <= 1'b0;
		end
		else
		begin
			rx_sh_reg <= {rx_sh_reg[1:0], async_rx_i};
			sck_sh_reg <= {sck_sh_reg[1:0], sclk_i};
			sel_sh_reg <= {sel_sh_reg[1:0], sel_n_i};
			mosi_sh_reg <= {mosi_sh_reg[1:0], mosi_i};
			if (rx_sh_reg[1] == rx_sh_reg[2])
				rx_f_reg <= rx_sh_reg[2];
			if (sck_sh_reg[1] == sck_sh_reg[2])
				sck_f_reg <= sck_sh_reg[2];
			if (sel_sh_reg[1] == sel_sh_reg[2])
				sel_f_reg <= sel_sh_reg[2];
			if (mosi_sh_reg[1] == mosi_sh_reg[2])
				mosi_f_reg <= mosi_sh_reg[2];
		end
	end

	// ==========================================================================
	// Port lock.
	lock_e lock_reg;
	logic rx_prev_reg;
	wire rx_fall = rx_prev_reg & ~rx_f_reg;

	// ==========================================================================
	// Baud detection: count clocks between first and tenth falling edge of the sync pattern.
	logic [3:0] edge_cnt_reg;
	logic [DIV_W+4:0] span_reg;
	logic [DIV_W-1:0] div_reg;
	logic locked_reg;
	logic detect_done;
	logic [DIV_W-1:0] new_div;

	// Rounded clocks per bit from the span of 18 bit times.
	always_comb
	begin
		new_div = DIV_W'((span_reg + (SYNC_SPAN_BITS / 2)) / SYNC_SPAN_BITS);
		detect_done = !locked_reg && (lock_reg != LOCK_SYNC) && rx_fall
			&& edge_cnt_reg == 4'(SYNC_FALL_EDGES - 1);
	end

	// Timed against the crystal clock directly.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_prev_reg <= 1'b1;
			edge_cnt_reg <= 4'h0;
			span_reg <= '0;
			div_reg <= '0;
			locked_reg <= 1'b0;
		end
		else
		begin
			rx_prev_reg <= rx_f_reg;
			if (!locked_reg && lock_reg != LOCK_SYNC)
			begin
				if (edge_cnt_reg != 4'h0)
					span_reg <= span_reg + 1'b1;
				if (detect_done)
				begin
					// Divisor below 16 would exceed the port's ceiling: retry.
					if (new_div >= DIV_W'(MIN_CLKS_PER_BIT))
					begin
						div_reg <= new_div;
						locked_reg <= 1'b1;
					end
					edge_cnt_reg <= 4'h0;
					span_reg <= '0;
				end
				else if (rx_fall)
					edge_cnt_reg <= edge_cnt_reg + 4'h1;
			end
		end
	end

	// ==========================================================================
	// Async receiver: 8N1 at the detected divisor.
	logic [DIV_W-1:0] rcnt_reg;
	logic [3:0] rbit_reg;
	logic [7:0] rshift_reg;
	logic rbusy_reg;
	logic [7:0] arx_reg;
	logic arx_valid_reg;

	// Start on falling edge, sample mid-bit, check stop bit.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rcnt_reg <= '0;
			rbit_reg <= 4'h0;
			rshift_reg <= 8'h00;
			rbusy_reg <= 1'b0;
			arx_reg <= 8'h00;
			arx_valid_reg <= 1'b0;
		end
		else
		begin
			arx_valid_reg <= 1'b0;
			if (!rbusy_reg)
			begin
				// Only once baud is known and async port owns the link.
				if (locked_reg && lock_reg == LOCK_ASYNC && rx_fall)
				begin
					rbusy_reg <= 1'b1;
					rbit_reg <= 4'h0;
					rcnt_reg <= div_reg >> 1;
				end
			end
			else if (rcnt_reg != '0)
				rcnt_reg <= rcnt_reg - 1'b1;
			else
			begin
				rcnt_reg <= div_reg - 1'b1;
				rbit_reg <= rbit_reg + 4'h1;
				if (rbit_reg == 4'h0 && rx_f_reg)
					rbusy_reg <= 1'b0; // False start.
				else if (rbit_reg >= 4'h1 && rbit_reg <= 4'(DATA_BITS))
					rshift_reg <= {rx_f_reg, rshift_reg[7:1]};
				else if (rbit_reg == 4'(DATA_BITS + 1))
				begin
					rbusy_reg <= 1'b0;
					arx_reg <= rshift_reg;
					arx_valid_reg <= rx_f_reg; // Framing error drops byte.
				end
			end
		end
	end

	// ==========================================================================
	// Synchronous slave.
	byte_stream_if srx ();
	logic [7:0] sync_tx_reg;
	sync_port_slave u_sync (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.sclk_i(sck_f_reg),
		.sel_n_i(sel_f_reg),
		.mosi_i(mosi_f_reg),
		.enable_i(lock_reg != LOCK_ASYNC),
		.tx_byte_i(sync_tx_reg),
		.miso_o(miso_o),
		.miso_oe_n_o(miso_oe_n_o),
		.rx(srx)
	);

	// First valid traffic picks the port; held until reset.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			lock_reg <= LOCK_NONE;
		else if (lock_reg == LOCK_NONE)
		begin
			if (detect_done && new_div >= DIV_W'(MIN_CLKS_PER_BIT))
				lock_reg <= LOCK_ASYNC;
			else if (srx.valid && srx.data != ZERO_BYTE)
				lock_reg <= LOCK_SYNC;
		end
	end

	// ==========================================================================
	// Merge receive streams, dropping zero padding.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rx_data_o <= 8'h00;
			rx_valid_o <= 1'b0;
		end
		else
		begin
			rx_valid_o <= 1'b0;
			if (lock_reg == LOCK_ASYNC && arx_valid_reg && arx_reg != ZERO_BYTE)
			begin
				rx_data_o <= arx_reg;
				rx_valid_o <= 1'b1;
			end
			else if (lock_reg != LOCK_ASYNC && srx.valid && srx.data != ZERO_BYTE)
			begin
				rx_data_o <= srx.data;
				rx_valid_o <= 1'b1;
			end
		end
	end

	// ==========================================================================
	// Transmit: detection reply, verdicts and packet bytes.
	logic [DIV_W-1:0] tcnt_reg;
	logic [3:0] tbit_reg;
	logic [9:0] tframe_reg;
	logic tbusy_reg;
	logic reply_pend_reg;
	logic [7:0] pend_byte_reg;
	logic pend_reg;

	// Queue one byte: baud reply beats verdict beats packet data.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pend_reg <= 1'b0;
			pend_byte_reg <= 8'h00;
			reply_pend_reg <= 1'b0;
		end
		else
		begin
			if (detect_done && new_div >= DIV_W'(MIN_CLKS_PER_BIT)
				&& lock_reg != LOCK_SYNC)
				reply_pend_reg <= 1'b1;
			if (!pend_reg)
			begin
				if (reply_pend_reg)
				begin
					pend_byte_reg <= ACK_BYTE;
					pend_reg <= 1'b1;
					reply_pend_reg <= 1'b0;
				end
				else if (verdict_valid_i)
				begin
					pend_byte_reg <= verdict_good_i ? ACK_BYTE : NAK_BYTE;
					pend_reg <= 1'b1;
				end
				else if (tx_valid_i)
				begin
					pend_byte_reg <= tx_data_i;
					pend_reg <= 1'b1;
				end
			end
			else if (lock_reg == LOCK_ASYNC ? !tbusy_reg : srx.valid)
				pend_reg <= 1'b0;
		end
	end

	assign tx_ready_o = !pend_reg && !reply_pend_reg && !verdict_valid_i;

	// Async shifter and synchronous reply byte (zeros when idle).
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tcnt_reg <= '0;
			tbit_reg <= 4'h0;
			tframe_reg <= 10'h3ff;
			tbusy_reg <= 1'b0;
			sync_tx_reg <= 8'h00;
		end
		else
		begin
			if (srx.valid)
				sync_tx_reg <= (pend_reg && lock_reg != LOCK_ASYNC) ? pend_byte_reg : ZERO_BYTE;
			if (!tbusy_reg)
			begin
				if (pend_reg && lock_reg == LOCK_ASYNC)
				begin
					tframe_reg <= {1'b1, pend_byte_reg, 1'b0};
					tbusy_reg <= 1'b1;
					tbit_reg <= 4'h0;
					tcnt_reg <= div_reg - 1'b1;
				end
			end
			else if (tcnt_reg != '0)
				tcnt_reg <= tcnt_reg - 1'b1;
			else
			begin
				tcnt_reg <= div_reg - 1'b1;
				tframe_reg <= {1'b1, tframe_reg[9:1]};
				tbit_reg <= tbit_reg + 4'h1;
				if (tbit_reg == 4'(DATA_BITS + 1))
					tbusy_reg <= 1'b0;
			end
		end
	end

	assign async_tx_o = tframe_reg[0];
	assign baud_locked_o = locked_reg;
	assign port_o = lock_reg;
	assign divisor_o = div_reg;

	// ==========================================================================
	// Checks.
	AST_LOCK_HOLDS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		lock_reg != LOCK_NONE |=> lock_reg == $past(lock_reg))
		else $error("port lock changed");
	AST_DIV_FLOOR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		locked_reg |-> div_reg >= DIV_W'(MIN_CLKS_PER_BIT))
		else $error("divisor below sixteen");
	AST_REPLY_QUEUED: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$rose(locked_reg) |-> reply_pend_reg)
		else $error("no reply after detection");
	AST_NO_ZERO_OUT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rx_valid_o |-> rx_data_o != 8'h00)
		else $error("zero byte passed");
	AST_NAK_VALUE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		(!pend_reg && !reply_pend_reg && verdict_valid_i && !verdict_good_i)
		|=> pend_byte_reg == NAK_BYTE)
		else $error("bad negative acknowledge");
	AST_STOP_BIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!tbusy_reg |-> async_tx_o)
		else $error("line not idle high");
	AST_SYNC_MUTE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		lock_reg == LOCK_ASYNC |-> miso_oe_n_o)
		else $error("sync port driven while async locked");
	AST_DIV_STABLE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		locked_reg |=> div_reg == $past(div_reg))
		else $error("divisor changed after lock");

endmodule
`default_nettype wire

// File: verilog/loader_link_pkg.sv
// Constants and types shared by the serial loader link front end.
`default_nettype none
package loader_link_pkg;

	// ==========================================================================
	// Byte values.
	localparam logic [7:0] SYNC_BYTE = 8'h55;
	localparam logic [7:0] ACK_BYTE = 8'hcc;
	localparam logic [7:0] NAK_BYTE = 8'h33;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ==========================================================================
	// Framing and timing counts.
	localparam int DATA_BITS = 8;
	// Two sync bytes hold ten falling edges: five in each frame, at the start bit
	// and at the four zero data bits, bits 1, 3, 5 and 7.
	localparam int SYNC_FALL_EDGES = 10;
	// Bit times spanned between first and last counted falling edge.
	localparam int SYNC_SPAN_BITS = 18;
	// Minimum clocks per bit: async divisor floor from the clock/16 ceiling.
	localparam int MIN_CLKS_PER_BIT = 16;
	localparam int DIV_W = 16;

	// Port lock state.
	typedef enum logic [1:0] {LOCK_NONE, LOCK_ASYNC, LOCK_SYNC} lock_e;

endpackage
`default_nettype wire

// File: verilog/byte_stream_if.sv
// Byte stream carrier between the link front end and its shift engine.
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
	logic [7:0] data; // Byte value.
	logic valid; // Byte present.
	modport src (output data, output valid);
	modport dst (input data, input valid);
endinterface
`default_nettype wire

// File: verilog/sync_port_slave.sv
// Synchronous serial slave, clock phase 1 and polarity 1, oversampled.
`timescale 1ns/1ps
`default_nettype none
module sync_port_slave
	import loader_link_pkg::*;
(
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Filtered pins and port enable.
	input wire logic sclk_i,
	input wire logic sel_n_i,
	input wire logic mosi_i,
	input wire logic enable_i,
	// Byte to send next.
	input wire logic [7:0] tx_byte_i,
	// Pin outputs.
	output logic miso_o,
	output logic miso_oe_n_o,
	// Received bytes.
	byte_stream_if.src rx
);

	// ==========================================================================
	// Edge detection on the already filtered serial clock.
	logic sclk_reg;
	logic [2:0] bit_reg;
	logic [7:0] shift_reg;
	logic [7:0] out_reg;
	logic [7:0] rx_reg;
	logic rx_valid_reg;
	wire fall = sclk_reg & ~sclk_i;
	wire rise = ~sclk_reg & sclk_i;
	wire act = enable_i & ~sel_n_i;

	// Phase 1, polarity 1: data changes on falling edge, sampled on rising.
	always_ff @(posedge clock_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			sclk_reg <= 1'b1;
			bit_reg <= 3'h0;
			shift_reg <= 8'h00;
			out_reg <= 8'h00;
			rx_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
		end
		else
		begin
			sclk_reg <= sclk_i;
			rx_valid_reg <= 1'b0;
			if (!act)
			begin
				// Deselected: restart the byte and preload the reply.
				bit_reg <= 3'h0;
				out_reg <= tx_byte_i;
			end
			else if (fall && bit_reg == 3'h0)
				out_reg <= tx_byte_i;
			else if (fall)
				out_reg <= {out_reg[6:0], 1'b0};
			else if (rise)
			begin
				shift_reg <= {shift_reg[6:0], mosi_i};
				bit_reg <= bit_reg + 3'h1;
				if (bit_reg == 3'h7)
				begin
					rx_reg <= {shift_reg[6:0], mosi_i};
					rx_valid_reg <= 1'b1;
				end
			end
		end
	end

	// Master supplies the clock; slave only drives data when selected.
	assign miso_o = out_reg[7];
	assign miso_oe_n_o = ~act;
	assign rx.data = rx_reg;
	assign rx.valid = rx_valid_reg;

	// Valid only pulses for a single cycle.
	AST_RX_PULSE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		rx.valid |=> !rx.valid) else $error("sync rx valid held");

endmodule
`default_nettype wire

// File: verif/host_link_model.sv
// Host model that masters both serial ports of the loader link.
`timescale 1ns/1ps
`default_nettype none
module host_link_model
	import loader_link_pkg::*;
(
	// Clock that paces the host's bit timing.
	input wire logic clock_i,
	// Loader outputs seen by the host.
	input wire logic async_tx_i,
	input wire logic miso_i,
	input wire logic miso_oe_n_i,
	// Host drive toward the loader.
	output logic async_rx_o,
	output logic sclk_o,
	output logic sel_n_o,
	output logic mosi_o
);
	// =====================================================================
	// State
	logic drive_seen; // Set once the loader drives the slave data line.
	// The slave data line has a pull-up, so it reads high while released.
	wire logic miso_line = miso_oe_n_i ? 1'b1 : miso_i;

	// Async, clock and select lines idle high, data line low; the serial clock stands still high outside frames.
	initial
	begin
		async_rx_o = 1'b1;
		sclk_o = 1'b1;
		sel_n_o = 1'b1;
		mosi_o = 1'b0;
		drive_seen = 1'b0;
	end

	// =====================================================================
	// Asynchronous port
	// One character, start bit, eight data bits LSB first, one stop bit.
	task automatic send_async(input logic [7:0] b, input int d);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clock_i);
			#5 async_rx_o = frame[i];
			repeat (d - 1) @(posedge clock_i);
		end
	endtask

	// The sync pattern is two sync bytes sent back to back.
	task automatic send_pattern(input int d);
		send_async(SYNC_BYTE, d);
		send_async(SYNC_BYTE, d);
	endtask

	// Receives one character; bit 8 is set on a timeout or a low stop bit.
	task automatic recv_async(input int d, output logic [8:0] b);
		int n;
		b = 9'h1ff;
		n = 0;
		while (async_tx_i !== 1'b0 && n < 4000)
		begin
			@(negedge clock_i);
			n++;
		end
		if (n < 4000)
		begin
			repeat (d / 2) @(negedge clock_i);
			for (int i = 0; i < 8; i++)
			begin
				repeat (d) @(negedge clock_i);
				b[i] = async_tx_i;
			end
			repeat (d) @(negedge clock_i);
			b[8] = ~async_tx_i;
		end
	endtask

	// =====================================================================
	// Synchronous port
	// One byte as master, MSB first: data moves on the falling clock edge
	// and both sides sample on the rising edge, 16 clocks per bit.
	task automatic spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
		@(posedge clock_i);
		#5 sel_n_o = 1'b0;
		repeat (8) @(posedge clock_i);
		for (int i = 7; i >= 0; i--)
		begin
			#5 sclk_o = 1'b0;
			mosi_o = tx[i];
			repeat (8) @(posedge clock_i);
			#5 sclk_o = 1'b1;
			rx[i] = miso_line;
			if (miso_oe_n_i === 1'b0)
				drive_seen = 1'b1;
			repeat (8) @(posedge clock_i);
		end
		#5 sel_n_o = 1'b1;
		// A released data line must not keep showing the last bit.
		mosi_o = ~mosi_o;
		// Stay deselected long enough for the loader's pin filter to see it.
		repeat (4) @(posedge clock_i);
	endtask
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the serial loader link front end.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import loader_link_pkg::*;

	// =====================================================================
	// Signals
	logic clock_i, rst_n_i, async_rx_i, async_tx_o, sclk_i, sel_n_i, mosi_i;
	logic miso_o, miso_oe_n_o, rx_valid_o, tx_valid_i, tx_ready_o;
	logic verdict_valid_i, verdict_good_i, baud_locked_o;
	logic [7:0] rx_data_o, tx_data_i, b, r;
	logic [1:0] port_o;
	logic [DIV_W-1:0] divisor_o;
	logic [8:0] got;
	logic [15:0] exp_q[$]; // Bytes the model expects on the receive side.
	int num_errors, compares, d;
	integer seed;

	serial_flash_loader_link dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.async_rx_i(async_rx_i), .async_tx_o(async_tx_o), .sclk_i(sclk_i),
		.sel_n_i(sel_n_i), .mosi_i(mosi_i), .miso_o(miso_o),
		.miso_oe_n_o(miso_oe_n_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
		.tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
		.verdict_valid_i(verdict_valid_i), .verdict_good_i(verdict_good_i),
		.baud_locked_o(baud_locked_o), .port_o(port_o), .divisor_o(divisor_o));

	host_link_model host (.clock_i(clock_i), .async_tx_i(async_tx_o), .miso_i(miso_o),
		.miso_oe_n_i(miso_oe_n_o), .async_rx_o(async_rx_i), .sclk_o(sclk_i),
		.sel_n_o(sel_n_i), .mosi_o(mosi_i));

	// 20 MHz crystal clock.
	initial
	begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	// =====================================================================
	// Helpers
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("Counts: %0d compares, %0d mismatches", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Every received byte must be the next one that the model expects.
	always @(negedge clock_i)
		if (rx_valid_o === 1'b1)
		begin
			if (exp_q.size() == 0)
				check({8'h01, rx_data_o}, 16'h0000);
			else
				check({8'h00, rx_data_o}, exp_q.pop_front());
		end

	// Reset is held for five cycles, then five more pass for the input filters.
	task automatic do_reset;
		@(posedge clock_i);
		#5 rst_n_i = 1'b0;
		repeat (5) @(posedge clock_i);
		check({13'h0, async_tx_o, miso_oe_n_o, 1'b0}, 16'h0006);
		check({14'h0, port_o}, 16'h0000);
		#5 rst_n_i = 1'b1;
		repeat (5) @(posedge clock_i);
	endtask

	task automatic pulse_verdict(input logic good);
		@(posedge clock_i);
		#5 verdict_valid_i = 1'b1;
		verdict_good_i = good;
		@(posedge clock_i);
		#5 verdict_valid_i = 1'b0;
	endtask

	// Offers one outgoing byte and holds it until ready is seen high.
	task automatic send_tx(input logic [7:0] v);
		int n;
		n = 0;
		@(posedge clock_i);
		#5 tx_data_i = v;
		tx_valid_i = 1'b1;
		// Ready is looked at mid-cycle, where it has settled before the taking edge.
		@(negedge clock_i);
		while (tx_ready_o !== 1'b1 && n < 3000)
		begin
			@(negedge clock_i);
			n++;
		end
		@(posedge clock_i);
		#5 tx_valid_i = 1'b0;
		if (n >= 3000)
		begin
			num_errors++;
			close_out();
		end
	endtask

	// Clocks out zero padding until the loader returns a non-zero byte.
	task automatic poll_sync(output logic [7:0] v);
		v = 8'h00;
		for (int i = 0; i < 4 && v === 8'h00; i++)
			host.spi_xfer(8'h00, v);
	endtask

	// A hang counts as a mismatch.
	initial
	begin
		repeat (100000) @(posedge clock_i);
		num_errors++;
		close_out();
	end

	// =====================================================================
	// Main sequence
	initial
	begin
		seed = 32'h8eae8428;
		num_errors = 0;
		compares = 0;
		rst_n_i = 1'b0;
		tx_data_i = 8'h00;
		tx_valid_i = 1'b0;
		verdict_valid_i = 1'b0;
		verdict_good_i = 1'b0;
		do_reset();

		// Asynchronous port: a too-fast pattern is refused, the retry locks.
		host.send_pattern(12);
		repeat (480) @(posedge clock_i);
		check({15'h0, baud_locked_o}, 16'h0000);
		d = 32 + ($random(seed) & 15);
		fork
			host.send_pattern(d);
			host.recv_async(d, got);
		join
		check({7'h0, got}, {8'h00, ACK_BYTE});
		check(divisor_o, 16'(d));
		check({14'h0, port_o}, 16'(LOCK_ASYNC));
		host.send_async(8'h00, d);
		for (int k = 0; k < 3; k++)
		begin
			b = 8'($random(seed)) | 8'h10;
			exp_q.push_back({8'h00, b});
			host.send_async(b, d);
		end
		for (int k = 0; k < 2; k++)
		begin
			fork
				pulse_verdict(k == 0);
				host.recv_async(d, got);
			join
			check({7'h0, got}, {8'h00, (k == 0) ? ACK_BYTE : NAK_BYTE});
		end
		b = 8'($random(seed));
		fork
			send_tx(b);
			host.recv_async(d, got);
		join
		check({7'h0, got}, {8'h00, b});
		host.spi_xfer(8'ha5, r);
		check({15'h0, host.drive_seen}, 16'h0000);
		check({14'h0, port_o}, 16'(LOCK_ASYNC));
		check(16'(exp_q.size()), 16'h0000);
		$display("Test async port done");

		// Synchronous port after a second reset.
		do_reset();
		host.spi_xfer(8'h00, r);
		check({14'h0, port_o}, 16'(LOCK_NONE));
		b = 8'($random(seed)) | 8'h01;
		exp_q.push_back({8'h00, b});
		host.spi_xfer(b, r);
		check({14'h0, port_o}, 16'(LOCK_SYNC));
		check({15'h0, host.drive_seen}, 16'h0001);
		host.send_pattern(d);
		repeat (40) @(posedge clock_i);
		check({15'h0, baud_locked_o}, 16'h0000);
		check({14'h0, port_o}, 16'(LOCK_SYNC));
		for (int k = 0; k < 2; k++)
		begin
			pulse_verdict(k == 1);
			poll_sync(r);
			check({8'h00, r}, {8'h00, (k == 1) ? ACK_BYTE : NAK_BYTE});
		end
		b = 8'($random(seed)) | 8'h02;
		fork
			send_tx(b);
			poll_sync(r);
		join
		check({8'h00, r}, {8'h00, b});
		check(16'(exp_q.size()), 16'h0000);
		$display("Test sync port done");
		close_out();
	end
endmodule
`default_nettype wire
